// ### common/fap_pkg.sv
// Shared constants for the flash converter output pipeline
package fap_pkg;
  localparam int CODE_W = 7;
  localparam int COMP_N = 128;
  localparam int WORD_W = CODE_W + 1;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W = 12;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] DATA_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] LAST_OFS = 12'h00C;
  localparam logic [ADDR_W-1:0] COUNT_OFS = 12'h010;
  localparam logic [ADDR_W-1:0] DROP_OFS = 12'h014;

  // Control field positions and reset value
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Status field positions, plus the valid bit of the data word
  localparam int ST_OVERRUN_BIT = 0;
  localparam int ST_BUBBLE_BIT = 1;
  localparam int ST_SHORT_BIT = 2;
  localparam int ST_PHASE_BIT = 3;
  localparam int ST_LEVEL_LSB = 8;
  localparam int DATA_VALID_BIT = 8;

  // Phase levels of the conversion clock
  localparam logic AUTOZERO_LEVEL = 1'b1;
  localparam logic SAMPLE_LEVEL = 1'b0;

  // Code for a full-scale input, overflow included
  localparam logic [WORD_W-1:0] FULL_SCALE_WORD = 8'hFF;
  localparam logic [CODE_W-1:0] CODE_ZERO = 7'h00;

  // Shortest useful sampling portion
  localparam int CLK_PERIOD_NS = 8;
  localparam int SAMPLE_MIN_NS = 12;
  localparam int SAMPLE_MIN_CYC = (SAMPLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    FAP_IDLE,
    FAP_AUTOZERO,
    FAP_SAMPLE
  } fap_phase_e;
endpackage : fap_pkg

// ### rtl/fap_fifo.sv
// Sample FIFO with valid/ready on both sides
`timescale 1ns/100ps
module fap_fifo import fap_pkg::*; #(
  parameter int WIDTH = WORD_W,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_reg;
  logic [PW-1:0] rdPtr_reg;
  logic [PW:0] count_reg;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  assign inReady = (count_reg != (PW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign level = count_reg;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : fap_fifo

// ### rtl/fap_top.sv
// Flash converter digital pipeline: latches, encoder, output latch, pins, APB
`timescale 1ns/100ps
module fap_top import fap_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic convClk,
  input wire logic [COMP_N-1:0] compResult,
  input wire logic dataBitsSelectLow,
  input wire logic outputGroupSelectHigh,
  output logic [CODE_W-1:0] dataPinOut,
  output logic [CODE_W-1:0] dataPinOe,
  output logic ovfPinOut,
  output logic ovfPinOe,
  output logic sampleStrobe,
  output logic sampleReady,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Thermometer count of the lower 127 comparators
  function automatic logic [CODE_W-1:0] encodeCount(input logic [COMP_N-1:0] t);
    logic [CODE_W-1:0] n;
    n = '0;
    for (int i = 0; i < COMP_N - 1; i++) begin
      n = n + CODE_W'(t[i]);
    end
    return n;
  endfunction : encodeCount

  // A one above a zero means a bubble in the thermometer
  function automatic logic hasBubble(input logic [COMP_N-1:0] t);
    logic b;
    b = 1'b0;
    for (int i = 1; i < COMP_N; i++) begin
      b = b | (t[i] & ~t[i-1]);
    end
    return b;
  endfunction : hasBubble

  // Phase tracking
  logic convPrev_reg;
  fap_phase_e phase_reg;
  fap_phase_e phase_next;
  wire convRise = (convClk == AUTOZERO_LEVEL) & (convPrev_reg == SAMPLE_LEVEL);
  wire inAutoZero = (convClk == AUTOZERO_LEVEL);
  wire inSample = (convClk == SAMPLE_LEVEL);

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      FAP_IDLE: begin
        if (inAutoZero) begin
          phase_next = FAP_AUTOZERO;
        end
      end
      FAP_AUTOZERO: begin
        if (inSample) begin
          phase_next = FAP_SAMPLE;
        end
      end
      FAP_SAMPLE: begin
        if (inAutoZero) begin
          phase_next = FAP_AUTOZERO;
        end
      end
      default: begin
        phase_next = FAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      convPrev_reg <= AUTOZERO_LEVEL;
      phase_reg <= FAP_IDLE;
    end else begin
      convPrev_reg <= convClk;
      phase_reg <= phase_next;
    end
  end

  // Comparator latches follow the comparators only while sampling
  logic [COMP_N-1:0] compLatch_reg;
  logic sampleSeen_reg;
  wire latchLoad = inSample & (phase_reg != FAP_IDLE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      compLatch_reg <= '0;
    end else if (latchLoad) begin
      compLatch_reg <= compResult;
    end
  end

  // A conversion needs a full auto-zero, sample, auto-zero sequence
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sampleSeen_reg <= 1'b0;
    end else if (latchLoad) begin
      sampleSeen_reg <= 1'b1;
    end
  end

  // Encoder: count plus overflow, full scale forces all ones
  wire topComp = compLatch_reg[COMP_N-1];
  wire [CODE_W-1:0] thermoCode = encodeCount(compLatch_reg);
  wire [WORD_W-1:0] encWord = topComp ? FULL_SCALE_WORD : {1'b0, thermoCode};
  wire bubble = hasBubble(compLatch_reg);

  // Output latch: only a rising conversion clock may change it
  logic [CODE_W-1:0] outCode_reg;
  logic outOvf_reg;
  wire loadOut = convRise & sampleSeen_reg & (phase_reg == FAP_SAMPLE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outCode_reg <= CODE_ZERO;
      outOvf_reg <= 1'b0;
    end else if (loadOut) begin
      outCode_reg <= encWord[CODE_W-1:0];
      outOvf_reg <= encWord[WORD_W-1];
    end
  end

  // Held stable until next load, no other writer
  assign dataPinOut = outCode_reg;
  assign ovfPinOut = outOvf_reg;

  // Three-state enables from the two selects
  wire dataEnable = ~dataBitsSelectLow & outputGroupSelectHigh;
  assign dataPinOe = {CODE_W{dataEnable}};
  assign ovfPinOe = outputGroupSelectHigh;

  // One-cycle pulse when a new sample reaches the output latch
  logic strobe_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= loadOut;
    end
  end
  assign sampleStrobe = strobe_reg;

  // Sampling portion length, to flag a too-short low pulse
  logic [3:0] lowCnt_reg;
  wire shortSample = convRise & (phase_reg == FAP_SAMPLE) & (lowCnt_reg < 4'(SAMPLE_MIN_CYC));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowCnt_reg <= '0;
    end else if (inAutoZero) begin
      lowCnt_reg <= '0;
    end else if (lowCnt_reg != 4'hF) begin
      lowCnt_reg <= lowCnt_reg + 4'h1;
    end
  end

  // Control register
  logic [31:0] ctrl_reg;
  wire captureEn = ctrl_reg[CTRL_CAPTURE_BIT];
  wire flushReq = ctrl_reg[CTRL_FLUSH_BIT];

  // APB decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hitCtrl = (paddr == CTRL_OFS);
  wire hitStatus = (paddr == STATUS_OFS);
  wire hitData = (paddr == DATA_OFS);
  wire hitLast = (paddr == LAST_OFS);
  wire hitCount = (paddr == COUNT_OFS);
  wire hitDrop = (paddr == DROP_OFS);
  wire hitAny = hitCtrl | hitStatus | hitData | hitLast | hitCount | hitDrop;
  wire wrCtrl = access & pwrite & hitCtrl;
  wire wrStatus = access & pwrite & hitStatus;
  wire rdData = access & ~pwrite & hitData;

  // Sample FIFO, fed by each output latch load while capture is enabled
  logic fifoInReady;
  logic fifoOutValid;
  logic [WORD_W-1:0] fifoOutData;
  logic [$clog2(FIFO_DEPTH):0] fifoLevel;
  wire pushReq = loadOut & captureEn;
  wire overrun = pushReq & ~fifoInReady;

  fap_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .flush(flushReq),
    .inValid(pushReq),
    .inReady(fifoInReady),
    .inData(encWord),
    .outValid(fifoOutValid),
    .outReady(rdData),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  assign sampleReady = fifoInReady;

  // Control: flush bit self-clears after one cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_reg <= {30'h0, pwdata[CTRL_FLUSH_BIT], pwdata[CTRL_CAPTURE_BIT]};
    end else begin
      ctrl_reg[CTRL_FLUSH_BIT] <= 1'b0;
    end
  end

  // Sticky status flags, write one to clear, a new event wins
  logic overrunFlag_reg;
  logic bubbleFlag_reg;
  logic shortFlag_reg;
  wire clrOverrun = wrStatus & pwdata[ST_OVERRUN_BIT];
  wire clrBubble = wrStatus & pwdata[ST_BUBBLE_BIT];
  wire clrShort = wrStatus & pwdata[ST_SHORT_BIT];
  wire bubbleEvt = loadOut & bubble;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overrunFlag_reg <= 1'b0;
      bubbleFlag_reg <= 1'b0;
      shortFlag_reg <= 1'b0;
    end else begin
      overrunFlag_reg <= overrun | (overrunFlag_reg & ~clrOverrun);
      bubbleFlag_reg <= bubbleEvt | (bubbleFlag_reg & ~clrBubble);
      shortFlag_reg <= shortSample | (shortFlag_reg & ~clrShort);
    end
  end

  // Counters of delivered and dropped samples
  logic [31:0] sampleCount_reg;
  logic [31:0] dropCount_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sampleCount_reg <= '0;
      dropCount_reg <= '0;
    end else begin
      if (loadOut) begin
        sampleCount_reg <= sampleCount_reg + 32'h1;
      end
      if (overrun) begin
        dropCount_reg <= dropCount_reg + 32'h1;
      end
    end
  end

  // Read data selection
  wire [31:0] statusWord = {16'h0, 2'b0, fifoLevel, 4'h0, phase_reg == FAP_AUTOZERO,
                            shortFlag_reg, bubbleFlag_reg, overrunFlag_reg};
  wire [31:0] dataWord = {23'h0, fifoOutValid, fifoOutData};
  wire [31:0] lastWord = {24'h0, outOvf_reg, outCode_reg};
  wire [31:0] readMux = hitCtrl ? ctrl_reg :
                        hitStatus ? statusWord :
                        hitData ? dataWord :
                        hitLast ? lastWord :
                        hitCount ? sampleCount_reg :
                        hitDrop ? dropCount_reg : 32'h0;

  // Read data and error captured in setup, shown in the zero-wait access
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0 : readMux;
      pslverr_reg <= ~hitAny;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg & access;
  assign pready = access;

endmodule : fap_top

// ### sim/fap_top_asserts.sv
// Pin timing checks for the converter pipeline
`timescale 1ns/100ps
module fap_top_asserts import fap_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic convClk,
  input wire logic dataBitsSelectLow,
  input wire logic outputGroupSelectHigh,
  input wire logic [CODE_W-1:0] dataPinOut,
  input wire logic [CODE_W-1:0] dataPinOe,
  input wire logic ovfPinOut,
  input wire logic ovfPinOe,
  input wire logic sampleStrobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_data_oe;
    dataPinOe == {CODE_W{~dataBitsSelectLow & outputGroupSelectHigh}};
  endproperty
  a_data_oe: assert property (p_data_oe) else $error("data enable wrong");
  property p_ovf_oe;
    ovfPinOe == outputGroupSelectHigh;
  endproperty
  a_ovf_oe: assert property (p_ovf_oe) else $error("overflow enable wrong");
  property p_load_edge;
    ($changed(dataPinOut) || $changed(ovfPinOut)) |-> $past(convClk) && !$past(convClk, 2);
  endproperty
  a_load_edge: assert property (p_load_edge) else $error("latch moved off a rise");
  property p_hold_high;
    convClk && $past(convClk) |=> $stable(dataPinOut) && $stable(ovfPinOut);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("latch moved in auto-zero");
  property p_hold_low;
    !convClk |=> $stable(dataPinOut) && $stable(ovfPinOut);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("latch moved in sampling");
  property p_full;
    ovfPinOut |-> dataPinOut == FULL_SCALE_WORD[CODE_W-1:0];
  endproperty
  a_full: assert property (p_full) else $error("overflow without all ones");
  property p_strobe_pulse;
    sampleStrobe |=> !sampleStrobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_strobe_after;
    sampleStrobe |-> $past(convClk) && !$past(convClk, 2);
  endproperty
  a_strobe_after: assert property (p_strobe_after) else $error("strobe not after load");
endmodule : fap_top_asserts
bind fap_top fap_top_asserts u_chk (.clk(clk), .rst_b(rst_b), .convClk(convClk),
  .dataBitsSelectLow(dataBitsSelectLow), .outputGroupSelectHigh(outputGroupSelectHigh),
  .dataPinOut(dataPinOut), .dataPinOe(dataPinOe), .ovfPinOut(ovfPinOut),
  .ovfPinOe(ovfPinOe), .sampleStrobe(sampleStrobe));

// ### sim/fap_host_model.sv
// Host model: converter clock and comparator levels
`timescale 1ns/100ps
module fap_host_model import fap_pkg::*; (
  input wire logic clk,
  output logic convClk,
  output logic [COMP_N-1:0] compResult
);
  initial begin
    convClk = AUTOZERO_LEVEL;
    compResult = '0;
  end
  // Comparators are scrambled in auto-zero so a load there shows
  task automatic period(input int level, input int hi, input int lo);
    repeat (hi) begin
      @(posedge clk);
      convClk <= AUTOZERO_LEVEL;
      compResult <= ~compResult;
    end
    repeat (lo) begin
      @(posedge clk);
      convClk <= SAMPLE_LEVEL;
      compResult <= (level >= COMP_N) ? '1 : ((COMP_N'(1) << level) - 1);
    end
  endtask : period
  task automatic finish();
    @(posedge clk);
    convClk <= AUTOZERO_LEVEL;
  endtask : finish
endmodule : fap_host_model

// ### sim/tb.sv
// Self-checking bench for the converter pipeline
`timescale 1ns/100ps
module tb import fap_pkg::*; ;
  logic clk, rst_b, convClk, dataBitsSelectLow, outputGroupSelectHigh;
  logic [COMP_N-1:0] compResult;
  logic [CODE_W-1:0] dataPinOut, dataPinOe;
  logic ovfPinOut, ovfPinOe, sampleStrobe, sampleReady;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [WORD_W-1:0] expQ[$], fifoQ[$];
  int err_count = 0;
  int checks = 0;
  int lv, cnt;
  int codes[9] = '{0, 1, 32, 63, 64, 65, 96, 127, 128};
  fap_top dut (.clk, .rst_b, .convClk, .compResult, .dataBitsSelectLow, .outputGroupSelectHigh,
    .dataPinOut, .dataPinOe, .ovfPinOut, .ovfPinOe, .sampleStrobe, .sampleReady,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  fap_host_model host (.clk, .convClk, .compResult);
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      err_count++;
      stop_test();
    end
  endtask : apb
  // Queue holds words in conversion order
  task automatic conv(input int level, input int lo);
    expQ.push_back(level >= COMP_N ? FULL_SCALE_WORD : WORD_W'(level));
    host.period(level, 1, lo);
  endtask : conv
  task automatic wait_q();
    int n;
    n = 0;
    while (expQ.size() > 0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (expQ.size() > 0) begin
      err_count++;
      $display("Error %0t: sample missing", $time);
      stop_test();
    end
  endtask : wait_q
  always @(posedge clk) begin
    if (sampleStrobe === 1'b1) begin
      if (expQ.size() == 0) begin
        err_count++;
        $display("Error %0t: extra sample", $time);
      end else begin
        chk({ovfPinOut, dataPinOut}, expQ.pop_front());
      end
    end
  end
  initial begin
    #400000;
    err_count++;
    $display("Error %0t: timeout", $time);
    stop_test();
  end
  initial begin
    rst_b = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    dataBitsSelectLow = 0;
    outputGroupSelectHigh = 1;
    void'($urandom(98));
    repeat (10) @(posedge clk);
    rst_b <= 1;
    apb(0, CTRL_OFS, 0);
    chk(r, CTRL_RESET);
    apb(0, 12'hFF0, 0);
    chk(e, 1);
    chk(r, 0);
    $display("registers test done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      {dataBitsSelectLow, outputGroupSelectHigh} <= i[1:0];
      @(negedge clk);
      chk(dataPinOe, {CODE_W{i == 1}});
      chk(ovfPinOe, i[0]);
    end
    @(posedge clk);
    {dataBitsSelectLow, outputGroupSelectHigh} <= 2'b01;
    $display("select test done");
    foreach (codes[k]) begin
      // Last code gets a one-cycle sampling portion, which must be flagged
      conv(codes[k], (k == 8) ? 1 : SAMPLE_MIN_CYC);
      host.finish();
      wait_q();
    end
    apb(0, STATUS_OFS, 0);
    chk(r[ST_SHORT_BIT], 1);
    chk(r[ST_PHASE_BIT], 1);
    apb(1, STATUS_OFS, 32'h7);
    apb(0, STATUS_OFS, 0);
    chk(r[ST_SHORT_BIT], 0);
    // Cascade host: overflow of this converter turns its data bits off
    @(posedge clk);
    dataBitsSelectLow <= ovfPinOut;
    @(negedge clk);
    chk(dataPinOe, 0);
    chk(ovfPinOe, 1);
    chk(ovfPinOut, 1);
    @(posedge clk);
    dataBitsSelectLow <= 0;
    $display("coding test done");
    apb(1, CTRL_OFS, 32'h3);
    for (int i = 0; i < FIFO_DEPTH + 8; i++) begin
      lv = $urandom_range(COMP_N, 0);
      conv(lv, 2);
      fifoQ.push_back(expQ[$]);
    end
    host.finish();
    wait_q();
    chk(sampleReady, 0);
    apb(0, STATUS_OFS, 0);
    chk(r[ST_OVERRUN_BIT], 1);
    chk(r[ST_LEVEL_LSB +: 7], FIFO_DEPTH);
    apb(0, DROP_OFS, 0);
    chk(r, 8);
    apb(0, COUNT_OFS, 0);
    chk(r, $size(codes) + FIFO_DEPTH + 8);
    apb(0, LAST_OFS, 0);
    chk(r, fifoQ[$]);
    cnt = 0;
    for (int n = 0; n < FIFO_DEPTH + 8; n++) begin
      apb(0, DATA_OFS, 0);
      if (r[DATA_VALID_BIT] !== 1'b1) break;
      chk(r[WORD_W-1:0], fifoQ.pop_front());
      cnt++;
    end
    chk(cnt, FIFO_DEPTH);
    chk(sampleReady, 1);
    $display("stream test done");
    stop_test();
  end
endmodule : tb
